// >>> hw/dram_control_settings.sv
// Functional notes
// - Bit 15 low: upper/lower column strobes select bytes; high: lower strobe plus write strobes.
// - Bit 14 low: row strobe rises after access; high: stays low awaiting next access.
// - Bit 13 picks one or two row precharge cycles.
// - Bit 12 low: full access per transfer; high: page mode burst.
// - Bit 11 sets column strobe high duty: 50 or 35 percent.
// - Bit 10 high multiplexes row and column addresses on address lines.
// - Bits 9:8 set row shift of 8, 9 or 10 bits; code 11 reserved.
// - Without multiplexing, bits 9:8 pick compared row range A27-A8, A27-A9, A27-A10.
// - Control register resets with all fields zero.
//
// The Wishbone slave port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module dram_control_settings
	import dram_ctrl_pkg::*;
#(
	parameter int COL_TICKS = COL_TICKS_DEF
) (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [31:0] wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	input  wire logic        req_valid_i,
	input  wire dram_req_t   req_i,
	output logic             req_ready_o,
	output logic             done_o,
	output dram_pins_t       dram_o
);

	localparam int TW = $clog2(COL_TICKS);
	localparam logic [TW-1:0] TICK_LAST = TW'(COL_TICKS - 1);
	localparam logic [TW-1:0] HI_HALF   = TW'((COL_TICKS * DUTY_HALF_PCT) / 100);
	localparam logic [TW-1:0] HI_SHORT  = TW'((COL_TICKS * DUTY_SHORT_PCT) / 100);

	ctrl_reg_t         ctrl;
	seq_state_t        state;
	dram_req_t         cur;
	logic              row_open;
	logic              pend;
	logic [ADDR_W-1:0] open_row;
	logic [TW-1:0]     tick;
	logic [1:0]        pre_cnt;

	function automatic logic [3:0] row_shift(input ctrl_reg_t c);
		case ({c.row_shift_hi, c.row_shift_lo})
			2'b01:   return ROW_SHIFT_BASE + 4'h1;
			2'b10:   return ROW_SHIFT_BASE + 4'h2;
			default: return ROW_SHIFT_BASE; // Reserved code falls back to 8
		endcase
	endfunction : row_shift

	function automatic logic [ADDR_W-1:0] row_key(input logic [ADDR_W-1:0] a,
		input logic [3:0] s);
		return a >> s;
	endfunction : row_key

	function automatic logic [ADDR_W-1:0] col_bits(input logic [ADDR_W-1:0] a,
		input logic [3:0] s);
		return a & ~({ADDR_W{1'b1}} << s);
	endfunction : col_bits

	logic [3:0]    shift;
	logic [TW-1:0] hi_ticks;
	logic [1:0]    pre_len;
	logic          same_row;
	logic          col_act;
	logic          wb_take;

	assign shift    = row_shift(ctrl);
	assign hi_ticks = ctrl.column_strobe_duty_select ? HI_SHORT : HI_HALF;
	assign pre_len  = ctrl.precharge_length ? PRECHARGE_LONG : PRECHARGE_SHORT;
	assign same_row = row_open && (row_key(req_i.addr, shift) == open_row);
	assign col_act  = (state == ST_COL) && (tick >= hi_ticks);
	assign wb_take  = wb_cyc_i && wb_stb_i && !wb_ack_o;

	// Bus slave: one wait state, ack dropped the cycle after
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
		end else begin
			wb_ack_o <= wb_take;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_dat_o <= READ_ZERO;
		end else if (wb_take) begin
			if (wb_adr_i == CTRL_REG_ADDR) begin
				wb_dat_o <= {16'h0000, ctrl};
			end else if (wb_adr_i == STATUS_REG_ADDR) begin
				wb_dat_o <= {30'h0000_0000, row_open, state != ST_IDLE};
			end else begin
				wb_dat_o <= READ_ZERO;
			end
		end
	end

	// Low byte is reserved and stays zero
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl <= ctrl_reg_t'(CTRL_RESET);
		end else if (wb_take && wb_we_i && wb_sel_i[1] && wb_adr_i == CTRL_REG_ADDR) begin
			ctrl <= ctrl_reg_t'({wb_dat_i[15:8], 8'h00});
		end
	end

	// Access sequencer
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state       <= ST_IDLE;
			cur         <= '0;
			row_open    <= 1'b0;
			pend        <= 1'b0;
			open_row    <= '0;
			tick        <= '0;
			pre_cnt     <= 2'h0;
			req_ready_o <= 1'b0;
			done_o      <= 1'b0;
		end else begin
			req_ready_o <= 1'b0;
			done_o      <= 1'b0;
			case (state)
				ST_IDLE: begin
					if (req_valid_i) begin
						cur         <= req_i;
						req_ready_o <= 1'b1;
						if (ctrl.burst_select && same_row) begin
							state <= ST_COL;
							tick  <= '0;
						end else if (row_open) begin
							// Open row cannot serve this access: close it first
							state    <= ST_PRE;
							pre_cnt  <= 2'h0;
							row_open <= 1'b0;
							pend     <= 1'b1;
						end else begin
							state <= ST_ROW;
						end
					end
				end
				ST_ROW: begin
					open_row <= row_key(cur.addr, shift);
					row_open <= 1'b1;
					state    <= ST_COL;
					tick     <= '0;
				end
				ST_COL: begin
					if (tick == TICK_LAST) begin
						done_o <= 1'b1;
						tick   <= '0;
						if (ctrl.burst_select && req_valid_i && same_row) begin
							cur         <= req_i;
							req_ready_o <= 1'b1;
						end else if (ctrl.row_strobe_hold) begin
							state <= ST_IDLE;
						end else begin
							state    <= ST_PRE;
							pre_cnt  <= 2'h0;
							row_open <= 1'b0;
							pend     <= 1'b0;
						end
					end else begin
						tick <= tick + TW'(1);
					end
				end
				ST_PRE: begin
					if (pre_cnt == pre_len - 2'h1) begin
						state <= pend ? ST_ROW : ST_IDLE;
						pend  <= 1'b0;
					end else begin
						pre_cnt <= pre_cnt + 2'h1;
					end
				end
				default: begin
					state <= ST_IDLE;
				end
			endcase
		end
	end

	// Pins registered from sequencer state, one cycle behind it
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			dram_o <= '{row_strobe_n: 1'b1, column_strobe_upper_n: 1'b1,
				column_strobe_lower_n: 1'b1, write_strobe_upper_n: 1'b1,
				write_strobe_lower_n: 1'b1, write_enable_n: 1'b1, addr: '0};
		end else begin
			dram_o.row_strobe_n <= !((state == ST_ROW) || (state == ST_COL) ||
				((state == ST_IDLE) && row_open));
			if (ctrl.strobe_scheme_select) begin
				dram_o.column_strobe_upper_n <= 1'b1;
				dram_o.column_strobe_lower_n <= !col_act;
				dram_o.write_strobe_upper_n  <= !(col_act && cur.we && cur.be[1]);
				dram_o.write_strobe_lower_n  <= !(col_act && cur.we && cur.be[0]);
				dram_o.write_enable_n        <= 1'b1;
			end else begin
				dram_o.column_strobe_upper_n <= !(col_act && cur.be[1]);
				dram_o.column_strobe_lower_n <= !(col_act && cur.be[0]);
				dram_o.write_strobe_upper_n  <= 1'b1;
				dram_o.write_strobe_lower_n  <= 1'b1;
				dram_o.write_enable_n        <= !((state == ST_COL) && cur.we);
			end
			if (ctrl.address_multiplex_select && state == ST_ROW) begin
				dram_o.addr <= row_key(cur.addr, shift);
			end else if (ctrl.address_multiplex_select && state == ST_COL) begin
				dram_o.addr <= col_bits(cur.addr, shift);
			end else begin
				dram_o.addr <= cur.addr;
			end
		end
	end

	property p_scheme_we;
		@(posedge clk_i) disable iff (rst_i)
		$past(ctrl.strobe_scheme_select) |-> dram_o.column_strobe_upper_n;
	endproperty
	a_scheme_we: assert property (p_scheme_we) else $error("upper column strobe active");

	property p_scheme_cas;
		@(posedge clk_i) disable iff (rst_i)
		!$past(ctrl.strobe_scheme_select) |->
			(dram_o.write_strobe_upper_n && dram_o.write_strobe_lower_n);
	endproperty
	a_scheme_cas: assert property (p_scheme_cas) else $error("write strobe in cas scheme");

	property p_hold;
		@(posedge clk_i) disable iff (rst_i)
		(state == ST_COL && tick == TICK_LAST && ctrl.row_strobe_hold &&
			!(ctrl.burst_select && req_valid_i && same_row))
		|=> (state == ST_IDLE && row_open) ##1 !dram_o.row_strobe_n;
	endproperty
	a_hold: assert property (p_hold) else $error("row strobe not held");

	property p_precharge;
		@(posedge clk_i) disable iff (rst_i)
		($rose(state == ST_PRE) && ctrl.precharge_length && $stable(ctrl))
		|-> (state == ST_PRE) ##1 (state == ST_PRE) ##1 (state != ST_PRE);
	endproperty
	a_precharge: assert property (p_precharge) else $error("precharge length wrong");

	property p_full_access;
		@(posedge clk_i) disable iff (rst_i)
		(state == ST_IDLE && req_valid_i && row_open && !ctrl.burst_select)
		|=> state == ST_PRE;
	endproperty
	a_full_access: assert property (p_full_access) else $error("page reuse without burst");

	property p_duty;
		@(posedge clk_i) disable iff (rst_i)
		(state == ST_COL && tick < hi_ticks) |=> (dram_o.column_strobe_upper_n &&
			dram_o.column_strobe_lower_n);
	endproperty
	a_duty: assert property (p_duty) else $error("column strobe low too early");

	property p_no_mux;
		@(posedge clk_i) disable iff (rst_i)
		(state == ST_ROW && !ctrl.address_multiplex_select) |=> dram_o.addr == $past(cur.addr);
	endproperty
	a_no_mux: assert property (p_no_mux) else $error("address multiplexed");

	property p_shift9;
		@(posedge clk_i) disable iff (rst_i)
		(state == ST_ROW && ctrl.address_multiplex_select && !ctrl.row_shift_hi &&
			ctrl.row_shift_lo) |=> dram_o.addr == ($past(cur.addr) >> 9);
	endproperty
	a_shift9: assert property (p_shift9) else $error("row shift not 9");

	property p_compare8;
		@(posedge clk_i) disable iff (rst_i)
		(state == ST_IDLE && req_valid_i && row_open && ctrl.burst_select &&
			!ctrl.row_shift_hi && !ctrl.row_shift_lo &&
			req_i.addr[27:8] == cur.addr[27:8]) |=> state == ST_COL;
	endproperty
	a_compare8: assert property (p_compare8) else $error("row compare missed");

	// Looks forward from reset so the very first clock edge never sees unset state
	property p_reset;
		@(posedge clk_i)
		rst_i |=> (ctrl == ctrl_reg_t'(CTRL_RESET) && dram_o.row_strobe_n);
	endproperty
	a_reset: assert property (p_reset) else $error("control not cleared");

	c_page_hit: cover property (@(posedge clk_i) disable iff (rst_i)
		state == ST_IDLE && req_valid_i && ctrl.burst_select && same_row);
	c_burst: cover property (@(posedge clk_i) disable iff (rst_i)
		state == ST_COL && tick == TICK_LAST && req_ready_o == 1'b0 && ctrl.burst_select &&
		req_valid_i && same_row);
	c_long_pre: cover property (@(posedge clk_i) disable iff (rst_i)
		state == ST_PRE && pre_cnt == 2'h1);
	c_reg_write: cover property (@(posedge clk_i) disable iff (rst_i)
		wb_take && wb_we_i && wb_adr_i == CTRL_REG_ADDR);

endmodule : dram_control_settings

`default_nettype wire

// >>> hw/dram_ctrl_pkg.sv
package dram_ctrl_pkg;

	// Printed offsets are not word aligned: kept as indexes, byte address is index * 4
	localparam logic [31:0] CTRL_REG_INDEX   = 32'h05FF_FFAA;
	localparam logic [31:0] STATUS_REG_INDEX = 32'h05FF_FFAB;
	localparam logic [31:0] CTRL_REG_ADDR    = {CTRL_REG_INDEX[29:0], 2'b00};
	localparam logic [31:0] STATUS_REG_ADDR  = {STATUS_REG_INDEX[29:0], 2'b00};

	localparam logic [15:0] CTRL_RESET       = 16'h0000;
	localparam logic [31:0] READ_ZERO        = 32'h0000_0000;

	localparam int          ADDR_W           = 28;
	localparam logic [3:0]  ROW_SHIFT_BASE   = 4'h8;
	localparam logic [1:0]  PRECHARGE_SHORT  = 2'h1;
	localparam logic [1:0]  PRECHARGE_LONG   = 2'h2;
	localparam int          DUTY_HALF_PCT    = 50;
	localparam int          DUTY_SHORT_PCT   = 35;
	localparam int          COL_TICKS_DEF    = 20;

	// Field layout of the control register, bit 15 first
	typedef struct packed {
		logic       strobe_scheme_select;
		logic       row_strobe_hold;
		logic       precharge_length;
		logic       burst_select;
		logic       column_strobe_duty_select;
		logic       address_multiplex_select;
		logic       row_shift_hi;
		logic       row_shift_lo;
		logic [7:0] reserved;
	} ctrl_reg_t;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic              we;
		logic [1:0]        be;
	} dram_req_t;

	typedef struct packed {
		logic              row_strobe_n;
		logic              column_strobe_upper_n;
		logic              column_strobe_lower_n;
		logic              write_strobe_upper_n;
		logic              write_strobe_lower_n;
		logic              write_enable_n;
		logic [ADDR_W-1:0] addr;
	} dram_pins_t;

	typedef enum {ST_IDLE, ST_ROW, ST_COL, ST_PRE} seq_state_t;

endpackage : dram_ctrl_pkg

// >>> dv/dram_chip_model.sv
`timescale 1ns/1ps
`default_nettype none
// Watches the pins only: the block takes no data back from the memory
module dram_chip_model
	import dram_ctrl_pkg::*;
(
	input  wire logic        clk_i,
	input  wire logic        clr_i,
	input  wire dram_pins_t  pins_i,
	output logic      [7:0]  rows_o,
	output logic      [7:0]  pre_o,
	output logic      [7:0]  col_low_o,
	output logic      [27:0] row_addr_o,
	output logic      [27:0] col_addr_o,
	output logic      [4:0]  seen_low_o
);
	logic       prev_ras = 1'b1;
	logic       prev_cas = 1'b0;
	logic [7:0] hi_run   = 8'h00;
	logic       cas;
	assign cas = ~(pins_i.column_strobe_upper_n & pins_i.column_strobe_lower_n);
	always @(posedge clk_i) begin
		prev_ras <= pins_i.row_strobe_n;
		prev_cas <= cas;
		// Only meaningful with the row held low between accesses
		hi_run   <= pins_i.row_strobe_n ? hi_run + 8'h01 : 8'h00;
		if (clr_i) begin
			rows_o     <= 8'h00;
			seen_low_o <= 5'h00;
		end else begin
			seen_low_o <= seen_low_o | ~pins_i[ADDR_W+4:ADDR_W];
			if (prev_ras && !pins_i.row_strobe_n) begin
				rows_o     <= rows_o + 8'h01;
				pre_o      <= hi_run;
				row_addr_o <= pins_i.addr;
			end
			if (cas && !prev_cas) begin
				col_low_o  <= 8'h01;
				col_addr_o <= pins_i.addr;
			end else if (cas) begin
				col_low_o <= col_low_o + 8'h01;
			end
		end
	end
endmodule : dram_chip_model
`default_nettype wire

// >>> dv/dram_control_settings_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin n_mismatch++; \
	$display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); end end
module dram_control_settings_tb;
	import dram_ctrl_pkg::*;
	logic        clk  = 1'b0;
	logic        rst  = 1'b1;
	logic        cyc  = 1'b0;
	logic        stb  = 1'b0;
	logic        we   = 1'b0;
	logic [31:0] adr  = 32'h0000_0000;
	logic [31:0] wdat = 32'h0000_0000;
	logic [3:0]  sel  = 4'h0;
	logic        rv   = 1'b0;
	dram_req_t   rq   = '0;
	logic        clr  = 1'b0;
	logic [31:0] rdat;
	logic [31:0] q;
	logic        ack;
	logic        rdy;
	logic        done;
	dram_pins_t  pins;
	logic [7:0]  rows;
	logic [7:0]  pre;
	logic [7:0]  col_low;
	logic [27:0] row_a;
	logic [27:0] col_a;
	logic [4:0]  seen;
	int          n_mismatch = 0;
	int          num_checks = 0;
	always #2 clk = ~clk;
	dram_control_settings #(.COL_TICKS(20)) uut (.clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
		.wb_dat_o(rdat), .wb_ack_o(ack), .req_valid_i(rv), .req_i(rq), .req_ready_o(rdy),
		.done_o(done), .dram_o(pins));
	dram_chip_model mem (.clk_i(clk), .clr_i(clr), .pins_i(pins), .rows_o(rows), .pre_o(pre),
		.col_low_o(col_low), .row_addr_o(row_a), .col_addr_o(col_a), .seen_low_o(seen));
	task automatic test_done();
		$display("checks=%0d mismatches=%0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : test_done
	task automatic wb(input logic w, input logic [31:0] a, input logic [31:0] d,
		output logic [31:0] r);
		cyc  <= 1'b1;
		stb  <= 1'b1;
		we   <= w;
		adr  <= a;
		sel  <= 4'h3;
		wdat <= d;
		@(posedge clk);
		// Open ended: only the watchdog gives up on a silent slave
		while (ack !== 1'b1) begin
			@(posedge clk);
		end
		r = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		sel <= 4'h0;
		@(posedge clk);
	endtask : wb
	task automatic setc(input logic [7:0] v);
		wb(1'b1, CTRL_REG_ADDR, {16'h0000, v, 8'h00}, q);
	endtask : setc
	// One write access; fresh clears the pin monitor's tallies first
	task automatic acc(input logic [27:0] a, input logic [1:0] be, input logic fresh);
		int n;
		n = 0;
		clr <= fresh;
		rv  <= 1'b1;
		rq  <= '{addr: a, we: 1'b1, be: be};
		@(posedge clk);
		clr <= 1'b0;
		while (rdy !== 1'b1 && n < 50) begin
			@(posedge clk);
			n++;
		end
		rv <= 1'b0;
		while (done !== 1'b1 && n < 200) begin
			@(posedge clk);
			n++;
		end
		if (n >= 200) n_mismatch++;
		repeat (4) @(posedge clk);
	endtask : acc
	task automatic t_regs();
		wb(1'b0, CTRL_REG_ADDR, 32'h0000_0000, q);
		`CHK(q, 32'h0000_0000)
		`CHK(pins.row_strobe_n, 1'b1)
		wb(1'b1, CTRL_REG_ADDR, 32'h0000_FFFF, q);
		wb(1'b1, CTRL_REG_ADDR + 32'h0000_0100, 32'h0000_0000, q);
		wb(1'b0, CTRL_REG_ADDR + 32'h0000_0100, 32'h0000_0000, q);
		`CHK(q, 32'h0000_0000)
		wb(1'b0, CTRL_REG_ADDR, 32'h0000_0000, q);
		`CHK(q, 32'h0000_FF00)
	endtask : t_regs
	// Pin order in seen: upper col, lower col, upper write, lower write, write enable
	task automatic t_scheme();
		setc(8'h00);
		acc(28'h000_0100, 2'b01, 1'b1);
		`CHK(seen, 5'h09)
		acc(28'h000_0100, 2'b10, 1'b1);
		`CHK(seen, 5'h11)
		setc(8'h80);
		acc(28'h000_0100, 2'b10, 1'b1);
		`CHK(seen, 5'h0C)
	endtask : t_scheme
	task automatic t_duty();
		for (int d = 0; d < 2; d++) begin
			setc(d ? 8'h08 : 8'h00);
			acc(28'h000_0200, 2'b11, 1'b1);
			`CHK(col_low, d ? 8'h0D : 8'h0A)
		end
	endtask : t_duty
	task automatic t_mux();
		for (int c = 0; c < 4; c++) begin
			setc(8'h04 | 8'(c));
			acc(28'hABC_DEF5, 2'b11, 1'b1);
			`CHK(row_a, 28'hABC_DEF5 >> ((c == 3) ? 8 : 8 + c))
			`CHK(col_a, 28'hABC_DEF5 & ~(28'hFFF_FFFF << ((c == 3) ? 8 : 8 + c)))
		end
		setc(8'h00);
		acc(28'hABC_DEF5, 2'b11, 1'b1);
		`CHK(row_a, 28'hABC_DEF5)
		`CHK(col_a, 28'hABC_DEF5)
	endtask : t_mux
	task automatic t_ras();
		for (int p = 0; p < 2; p++) begin
			setc(p ? 8'h60 : 8'h40);
			acc(28'h010_0000, 2'b11, 1'b1);
			acc(28'h020_0000, 2'b11, 1'b0);
			`CHK(pre, p ? 8'h02 : 8'h01)
			`CHK(pins.row_strobe_n, 1'b0)
		end
		setc(8'h00);
		acc(28'h030_0000, 2'b11, 1'b1);
		`CHK(pins.row_strobe_n, 1'b1)
	endtask : t_ras
	task automatic t_burst();
		for (int c = 0; c < 3; c++) begin
			for (int b = 8; b < 10; b++) begin
				setc(8'h50 | 8'(c));
				acc(28'(c * 2 + b) << 20, 2'b11, 1'b1);
				acc((28'(c * 2 + b) << 20) | (28'h000_0001 << b), 2'b11, 1'b0);
				`CHK(rows, (b >= 8 + c) ? 8'h02 : 8'h01)
			end
		end
		setc(8'h40);
		acc(28'h070_0000, 2'b11, 1'b1);
		acc(28'h070_0001, 2'b11, 1'b0);
		`CHK(rows, 8'h02)
	endtask : t_burst
	// Second request held through the first access: page mode must reuse the open row
	task automatic t_page();
		setc(8'h10);
		clr <= 1'b1;
		rv  <= 1'b1;
		rq  <= '{addr: 28'h080_0000, we: 1'b1, be: 2'b11};
		@(posedge clk);
		clr <= 1'b0;
		while (rdy !== 1'b1) begin
			@(posedge clk);
		end
		rq <= '{addr: 28'h080_0004, we: 1'b1, be: 2'b11};
		@(posedge clk);
		while (rdy !== 1'b1) begin
			@(posedge clk);
		end
		rv <= 1'b0;
		while (done !== 1'b1) begin
			@(posedge clk);
		end
		@(posedge clk);
		while (done !== 1'b1) begin
			@(posedge clk);
		end
		repeat (4) @(posedge clk);
		`CHK(rows, 8'h01)
	endtask : t_page
	initial begin
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		t_regs();
		t_scheme();
		t_duty();
		t_mux();
		t_ras();
		t_burst();
		t_page();
		test_done();
	end
	// Whole run is near 1000 cycles; twenty times that means a hang
	initial begin
		#80000;
		n_mismatch++;
		test_done();
	end
endmodule : dram_control_settings_tb
`default_nettype wire
